//--- shared/dsb_regs.svh
// Constants of the two-word burst double-data-rate memory port
`ifndef DSB_REGS_SVH
`define DSB_REGS_SVH
`define DSB_DW_NARROW 18
`define DSB_DW_WIDE 36
`define DSB_AW_NARROW 21
`define DSB_AW_WIDE 20
`define DSB_FIFO_DEPTH 16
`endif

//--- shared/dsb_pkg.sv
// Types of the two-word burst double-data-rate memory port
package dsb_pkg;
   typedef enum logic {
      DSB_PH_IDLE = 1'b0,
      DSB_PH_BUSY = 1'b1
   } dsb_phase_e;
   typedef enum logic {
      DSB_LAT_ONE = 1'b0,
      DSB_LAT_ONE_HALF = 1'b1
   } dsb_lat_e;
endpackage

//--- hdl/dsb_port.sv
// Two-word burst double-data-rate static memory port, device side
//
// Behaviour
// - An access takes two input clock cycles; addresses accepted on alternate rising edges.
// - Write words captured on rising and falling edge of the input clock.
// - Read data launched by output clock pair, else by input clock pair.
// - Burst counter loads address bit zero, then moves two words per access.
// - Loop disable high: first read word 1.5 cycles after address capture.
// - Loop disable low: first read word one cycle after address capture.
// - Every K clock input passes an input register; ARRAY_HOLD gates the array write combinationally.
// - Read data shares the data pins; echo clocks accompany read data.
// - Writes finish in the array by internal timing, no external strobe.
// - Array is 2M words of 18 bits or 1M words of 36 bits.
`include "dsb_regs.svh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Dual-clock FIFO with gray-coded pointers

module dsb_afifo #(
   parameter int W = 8,
   parameter int DEPTH = `DSB_FIFO_DEPTH
) (
   input wire logic wclk,
   input wire logic wrst_n,
   input wire logic wvalid,
   output logic wready,
   input wire logic [W-1:0] wdata,
   input wire logic rclk,
   input wire logic rrst_n,
   output logic rvalid,
   input wire logic rready,
   output logic [W-1:0] rdata
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] buf_q [DEPTH];
   logic [PW:0] wbin_q, wgray_q, rbin_q, rgray_q;
   logic [PW:0] rg_w1_q, rg_w2_q, wg_r1_q, wg_r2_q;
   logic [PW:0] wbin_d, rbin_d;
   logic push, pop;

   assign push = wvalid & wready;
   assign pop = rvalid & rready;
   assign wbin_d = wbin_q + {{PW{1'b0}}, push};
   assign rbin_d = rbin_q + {{PW{1'b0}}, pop};
   // Full when the write pointer is one lap ahead of the read pointer
   assign wready = wgray_q != {~rg_w2_q[PW:PW-1], rg_w2_q[PW-2:0]};
   assign rvalid = rgray_q != wg_r2_q;
   assign rdata = buf_q[rbin_q[PW-1:0]];

   always_ff @(posedge wclk) begin
      if (push) begin
         buf_q[wbin_q[PW-1:0]] <= wdata;
      end
   end

   always_ff @(posedge wclk or negedge wrst_n) begin
      if (!wrst_n) begin
         wbin_q <= '0;
         wgray_q <= '0;
         rg_w1_q <= '0;
         rg_w2_q <= '0;
      end else begin
         wbin_q <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
         rg_w1_q <= rgray_q;
         rg_w2_q <= rg_w1_q;
      end
   end

   always_ff @(posedge rclk or negedge rrst_n) begin
      if (!rrst_n) begin
         rbin_q <= '0;
         rgray_q <= '0;
         wg_r1_q <= '0;
         wg_r2_q <= '0;
      end else begin
         rbin_q <= rbin_d;
         rgray_q <= rbin_d ^ (rbin_d >> 1);
         wg_r1_q <= wgray_q;
         wg_r2_q <= wg_r1_q;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Memory device top

module dsb_port #(
   parameter bit WIDE = 1'b0,
   parameter int DW = WIDE ? `DSB_DW_WIDE : `DSB_DW_NARROW,
   parameter int AW = WIDE ? `DSB_AW_WIDE : `DSB_AW_NARROW,
   parameter int FIFO_DEPTH = `DSB_FIFO_DEPTH
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic K_CLK,
   input wire logic C_CLK,
   input wire logic C_CLK_USE,
   input wire logic LOOP_DISABLE,
   input wire logic LD_N,
   input wire logic RW,
   input wire logic [AW-1:0] ADDR,
   input wire logic [DW-1:0] DQ_I,
   output logic [DW-1:0] DQ_O,
   output logic DQ_OE,
   output logic ECHO_CLOCK_PAIR_P,
   output logic ECHO_CLOCK_PAIR_N,
   input wire logic ARRAY_HOLD,
   output logic WR_BUSY
);
   localparam int FW = AW + 2 * DW;

   logic [DW-1:0] mem_q [2**AW];

   logic [AW-1:0] addr_q, waddr_q;
   logic ld_q, rw_q, wpend_q, busy_q;
   logic [DW-1:0] d_rise_q, d_fall_q;
   dsb_pkg::dsb_phase_e phase_q;
   logic lds1_q, lds2_q, lds3_q;
   dsb_pkg::dsb_lat_e lat_q;
   logic accept, rd_now, wr_now;
   logic [DW-1:0] rd_w0, rd_w1;
   logic rd_s1_q, rd_s2_q;
   logic [DW-1:0] rb0_q, rb1_q;

   logic launch_clk;
   logic pos_first, pos_second;
   logic [DW-1:0] pos_word0;
   logic [DW-1:0] q_pos_q, q_neg_q;
   logic oe_pos_q, oe_neg_q;

   logic f_wready, f_rvalid, f_rready;
   logic [FW-1:0] f_wdata, f_rdata;
   logic [AW-1:0] f_addr;
   logic burst_q;

   /////////////////////////////////////////////////////////////////////////////
   // Input registers on the link clock

   // Complementary input clock is taken as the falling edge of the true one
   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr_q <= '0;
         ld_q <= 1'b0;
         rw_q <= 1'b0;
         d_rise_q <= '0;
      end else begin
         addr_q <= ADDR;
         ld_q <= ~LD_N;
         rw_q <= RW;
         d_rise_q <= DQ_I;
      end
   end

   always_ff @(negedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         d_fall_q <= '0;
      end else begin
         d_fall_q <= DQ_I;
      end
   end

   // Static strap still passes three flops so a late change settles cleanly
   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lds1_q <= 1'b0;
         lds2_q <= 1'b0;
         lds3_q <= 1'b0;
         lat_q <= dsb_pkg::DSB_LAT_ONE;
      end else begin
         lds1_q <= LOOP_DISABLE;
         lds2_q <= lds1_q;
         lds3_q <= lds2_q;
         if (lds2_q == lds3_q) begin
            lat_q <= lds3_q ? dsb_pkg::DSB_LAT_ONE_HALF
                            : dsb_pkg::DSB_LAT_ONE;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Access sequencing

   // Load in the second cycle of an access is ignored
   assign accept = ld_q & (phase_q == dsb_pkg::DSB_PH_IDLE);
   assign rd_now = accept & rw_q;
   assign wr_now = accept & ~rw_q;
   assign rd_w0 = mem_q[addr_q];
   assign rd_w1 = mem_q[{addr_q[AW-1:1], ~addr_q[0]}];

   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         phase_q <= dsb_pkg::DSB_PH_IDLE;
      end else begin
         unique case (phase_q)
            dsb_pkg::DSB_PH_IDLE: begin
               if (accept) begin
                  phase_q <= dsb_pkg::DSB_PH_BUSY;
               end
            end
            dsb_pkg::DSB_PH_BUSY: begin
               phase_q <= dsb_pkg::DSB_PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wpend_q <= 1'b0;
         waddr_q <= '0;
      end else begin
         wpend_q <= wr_now;
         if (wr_now) begin
            waddr_q <= addr_q;
         end
      end
   end

   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_s1_q <= 1'b0;
         rd_s2_q <= 1'b0;
         rb0_q <= '0;
         rb1_q <= '0;
      end else begin
         rd_s1_q <= rd_now;
         rd_s2_q <= rd_s1_q;
         if (rd_now) begin
            rb0_q <= rd_w0;
            rb1_q <= rd_w1;
         end
      end
   end

   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= ~f_wready;
      end
   end
   assign WR_BUSY = busy_q;

   /////////////////////////////////////////////////////////////////////////////
   // Output launch

   // Select is a strap; the output clock may lag the input by under a half
   // cycle, so it rises after the input stage moved on and reads one later
   assign launch_clk = C_CLK_USE ? C_CLK : K_CLK;
   assign pos_first = C_CLK_USE ? rd_s1_q : rd_now;
   assign pos_second = C_CLK_USE ? rd_s2_q : rd_s1_q;
   assign pos_word0 = C_CLK_USE ? rb0_q : rd_w0;

   always_ff @(posedge launch_clk or negedge RST_N) begin
      if (!RST_N) begin
         q_pos_q <= '0;
         oe_pos_q <= 1'b0;
      end else if (pos_first && lat_q == dsb_pkg::DSB_LAT_ONE) begin
         q_pos_q <= pos_word0;
         oe_pos_q <= 1'b1;
      end else if (pos_second && lat_q == dsb_pkg::DSB_LAT_ONE_HALF) begin
         q_pos_q <= rb1_q;
         oe_pos_q <= 1'b1;
      end else begin
         oe_pos_q <= 1'b0;
      end
   end

   always_ff @(negedge launch_clk or negedge RST_N) begin
      if (!RST_N) begin
         q_neg_q <= '0;
         oe_neg_q <= 1'b0;
      end else if (rd_s1_q) begin
         q_neg_q <= (lat_q == dsb_pkg::DSB_LAT_ONE) ? rb1_q : rb0_q;
         oe_neg_q <= 1'b1;
      end else begin
         oe_neg_q <= 1'b0;
      end
   end

   // Double-rate output stage: the clock picks the half-cycle register
   assign DQ_O = launch_clk ? q_pos_q : q_neg_q;
   assign DQ_OE = launch_clk ? oe_pos_q : oe_neg_q;
   assign ECHO_CLOCK_PAIR_P = launch_clk & RST_N;
   assign ECHO_CLOCK_PAIR_N = ~launch_clk & RST_N;

   /////////////////////////////////////////////////////////////////////////////
   // Write path into the array

   // Both words are complete one edge after the falling-edge capture
   assign f_wdata = {waddr_q, d_rise_q, d_fall_q};

   dsb_afifo #(
      .W(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_wfifo (
      .wclk(K_CLK),
      .wrst_n(RST_N),
      .wvalid(wpend_q),
      .wready(f_wready),
      .wdata(f_wdata),
      .rclk(CORE_CLK),
      .rrst_n(RST_N),
      .rvalid(f_rvalid),
      .rready(f_rready),
      .rdata(f_rdata)
   );

   assign f_addr = f_rdata[FW-1:2*DW];
   assign f_rready = burst_q & ~ARRAY_HOLD;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         burst_q <= 1'b0;
      end else if (f_rvalid && !ARRAY_HOLD) begin
         burst_q <= ~burst_q;
      end
   end

   // Self-timed: one word per core cycle, no strobe from the controller
   // Limitation: a read issued right after a write may see the old words
   always_ff @(posedge CORE_CLK) begin
      if (f_rvalid && !ARRAY_HOLD) begin
         mem_q[{f_addr[AW-1:1], f_addr[0] ^ burst_q}] <= burst_q
            ? f_rdata[DW-1:0] : f_rdata[2*DW-1:DW];
      end
   end
endmodule
`default_nettype wire

//--- bench/dsb_port_asserts.sv
// Pin level checks of the memory port
`timescale 1ns/100ps
`default_nettype none
module dsb_port_asserts (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic K_CLK,
   input wire logic C_CLK,
   input wire logic C_CLK_USE,
   input wire logic LOOP_DISABLE,
   input wire logic LD_N,
   input wire logic RW,
   input wire logic DQ_OE,
   input wire logic ECHO_CLOCK_PAIR_P,
   input wire logic ECHO_CLOCK_PAIR_N,
   input wire logic ARRAY_HOLD,
   input wire logic WR_BUSY
);
   // Access accepted one rise after capture, and whether it reads
   logic acc_q;
   logic rd_q;
   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) acc_q <= 1'b0;
      else acc_q <= !LD_N && !acc_q;
   end
   always_ff @(posedge K_CLK or negedge RST_N) begin
      if (!RST_N) rd_q <= 1'b0;
      else if (!LD_N && !acc_q) rd_q <= RW;
   end
   ////////////////////////////////
   a_lat_one: assert property (@(negedge K_CLK) disable iff (!RST_N)
      acc_q && rd_q && !LOOP_DISABLE |-> !DQ_OE ##1 DQ_OE ##1 !DQ_OE)
      else $error("lat1");
   a_lat_half: assert property (@(negedge K_CLK) disable iff (!RST_N)
      acc_q && rd_q && LOOP_DISABLE |-> !DQ_OE [*2] ##1 DQ_OE ##1 !DQ_OE)
      else $error("lat15");
   a_write_quiet: assert property (@(negedge K_CLK) disable iff (!RST_N)
      acc_q && !rd_q |-> !DQ_OE [*2]) else $error("oe in write");
   a_oe_cause: assert property (@(negedge K_CLK) disable iff (!RST_N)
      DQ_OE |-> rd_q && (acc_q || $past(acc_q) || $past(acc_q, 2)))
      else $error("stray oe");
   a_echo_src: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ECHO_CLOCK_PAIR_P == (C_CLK_USE ? C_CLK : K_CLK)) else $error("echo");
   a_echo_pair: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ECHO_CLOCK_PAIR_P != ECHO_CLOCK_PAIR_N) else $error("echo pair");
   a_busy_drain: assert property (@(posedge K_CLK) disable iff (!RST_N)
      WR_BUSY && !ARRAY_HOLD |-> ##[1:8] !WR_BUSY) else $error("no drain");
   a_busy_cause: assert property (@(posedge K_CLK) disable iff (!RST_N)
      $rose(WR_BUSY) |-> ARRAY_HOLD) else $error("busy");
   c_slow: cover property (@(negedge K_CLK) acc_q && rd_q && LOOP_DISABLE);
   c_busy: cover property (@(posedge K_CLK) WR_BUSY);
   c_cclk: cover property (@(posedge CORE_CLK) C_CLK_USE && DQ_OE);
endmodule
bind dsb_port dsb_port_asserts u_chk (.CORE_CLK, .RST_N, .K_CLK, .C_CLK,
   .C_CLK_USE, .LOOP_DISABLE, .LD_N, .RW, .DQ_OE, .ECHO_CLOCK_PAIR_P,
   .ECHO_CLOCK_PAIR_N, .ARRAY_HOLD, .WR_BUSY);
`default_nettype wire

//--- bench/dsb_ctl_model.sv
// Memory controller model on the link side of the port
`timescale 1ns/100ps
`default_nettype none
module dsb_ctl_model #(
   parameter int AW = 21,
   parameter int DW = 18
) (
   input wire logic k_clk,
   output logic ld_n,
   output logic rw,
   output logic [AW-1:0] addr,
   output logic [DW-1:0] dq_i,
   input wire logic [DW-1:0] dq_o
);
   initial begin
      ld_n = 1'b1;
      rw = 1'b0;
      addr = '0;
      dq_i = '0;
   end
   // Load held over one rise only, so calls land on alternate rises
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0, w1);
      @(negedge k_clk) ld_n = 1'b0;
      rw = 1'b0;
      addr = a;
      @(negedge k_clk) ld_n = 1'b1;
      addr = ~a;
      // Data moves mid half cycle, away from both capture edges
      #12 dq_i = w0;
      @(posedge k_clk) #12 dq_i = w1;
   endtask
   // Samples mid half cycle; late data is taken as wrong
   task automatic rd(input logic [AW-1:0] a, input logic slow,
      output logic [DW-1:0] q0, q1);
      @(negedge k_clk) ld_n = 1'b0;
      rw = 1'b1;
      addr = a;
      @(negedge k_clk) ld_n = 1'b1;
      addr = ~a;
      @(posedge k_clk);
      if (slow) @(negedge k_clk);
      #12 q0 = dq_o;
      if (slow) @(posedge k_clk);
      else @(negedge k_clk);
      #12 q1 = dq_o;
   endtask
endmodule
`default_nettype wire

//--- bench/dsb_port_tb_top.sv
// Self-checking bench of the memory port
`timescale 1ns/100ps
`default_nettype none
module dsb_port_tb_top;
   logic core_clk = 1'b0, k_clk = 1'b0, rst_n = 1'b0;
   logic c_use = 1'b0, loop_dis = 1'b0, hold = 1'b0;
   wire c_clk, ld_n, rw, dq_oe, busy;
   wire [20:0] addr;
   wire [17:0] dq_i, dq_o;
   int err_total = 0, checks_done = 0, cyc = 0;
   assign #2 c_clk = k_clk;
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #1.3;
      forever #24 k_clk = ~k_clk;
   end
   dsb_port dut (.CORE_CLK(core_clk), .RST_N(rst_n), .K_CLK(k_clk),
      .C_CLK(c_clk), .C_CLK_USE(c_use), .LOOP_DISABLE(loop_dis),
      .LD_N(ld_n), .RW(rw), .ADDR(addr), .DQ_I(dq_i), .DQ_O(dq_o),
      .DQ_OE(dq_oe), .ECHO_CLOCK_PAIR_P(), .ECHO_CLOCK_PAIR_N(),
      .ARRAY_HOLD(hold), .WR_BUSY(busy));
   dsb_ctl_model ctl (.k_clk(k_clk), .ld_n(ld_n), .rw(rw), .addr(addr),
      .dq_i(dq_i), .dq_o(dq_o));
   ////////////////////////////////
   task automatic chk(input string what, input logic [35:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [17:0] pat(input logic [20:0] a);
      return a[17:0] ^ 18'h2A5C3;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One burst written, read back from both halves of the pair
   task automatic t_lat(input logic slow, input logic [20:0] a);
      logic [17:0] q0, q1;
      @(negedge core_clk) loop_dis = slow;
      repeat (5) @(posedge k_clk);
      ctl.wr(a, pat(a), pat(a ^ 21'h1));
      repeat (4) @(posedge k_clk);
      ctl.rd(a, slow, q0, q1);
      chk("word0", q0, pat(a));
      chk("word1", q1, pat(a ^ 21'h1));
      ctl.rd(a ^ 21'h1, slow, q0, q1);
      chk("swap0", q0, pat(a ^ 21'h1));
      chk("swap1", q1, pat(a));
   endtask
   task automatic t_cclk;
      logic [17:0] q0, q1;
      @(negedge core_clk) c_use = 1'b1;
      repeat (4) @(posedge k_clk);
      ctl.rd(21'h00005, loop_dis, q0, q1);
      chk("c word0", q0, pat(21'h00005));
      chk("c word1", q1, pat(21'h00004));
      @(negedge core_clk) loop_dis = 1'b0;
      repeat (5) @(posedge k_clk);
      ctl.rd(21'h00004, 1'b0, q0, q1);
      chk("c fast0", q0, pat(21'h00004));
      chk("c fast1", q1, pat(21'h00005));
      @(negedge core_clk) c_use = 1'b0;
   endtask
   // Array stalled: back-to-back writes fill the buffer until it refuses
   task automatic t_busy;
      logic [17:0] q0, q1;
      logic [20:0] a;
      @(negedge core_clk) hold = 1'b1;
      for (int i = 0; i < 20; i++) begin
         a = 21'(256 + 2 * i);
         ctl.wr(a, pat(a), pat(a ^ 21'h1));
      end
      chk("busy", busy, 1'b1);
      @(negedge core_clk) hold = 1'b0;
      repeat (10) @(posedge k_clk);
      #1 chk("idle", busy, 1'b0);
      ctl.rd(21'h00100, loop_dis, q0, q1);
      chk("f word0", q0, pat(21'h00100));
      chk("f word1", q1, pat(21'h00101));
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      rst_n = 1'b1;
      t_lat(1'b0, 21'h00005);
      t_lat(1'b1, 21'h1F0A2);
      t_cclk;
      t_busy;
      report_and_stop;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
endmodule
`default_nettype wire
